// [alarm_event_block.sv]
// directional overcurrent alarm: pick-up, direction check, angle memory, events
// assumes meas_valid pulses once per 5 ms period and inputs are synchronous to clk
// How it works
// (R1) eight parameter sets, one shared selector, writable while running
// (R2) each alarm change emits ON or OFF event with 1 ms stamp
// (R3) cumulative alarm event count, cleared by software request
// (R4) peak-to-peak mode takes magnitudes from raw samples, not RMS
// (R5) source gives three currents and four voltages every 5 ms
// (R6) each phase compared alone; any phase over threshold picks up
// (R7) release only below 97 % of threshold
// (R8) one threshold for all phases, 0.10 to 40.00, default 1.20
// (R9) direction codes forward, reverse, non-directional; last skips angle check
// (R10) sector half-width 1.0 to 170.0 degrees, default 88
// (R11) sector centre -180.0 to 180.0 degrees, default 0
// (R12) alarm needs magnitude condition and angle inside sector
// (R13) reference is positive sequence voltage angle, compared to current angle
// (R14) without it, healthy line voltage reference, faulty phase current
// (R15) during short-circuit, reference from impedance calculation
// (R16) below 1 V, hold pre-fault angle up to 0.5 s
// (R17) memory keeps angle from 100 ms before fault onset
// (R18) after hold expires, reference forced to zero degrees
// (R19) angle condition releases with 2 degrees hysteresis
// (R20) start asserts only while blocking input inactive
// (R21) last twelve operation records with stamp and fault data
// (R22) alarm on with start, off when magnitude or angle releases
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "dir_alarm_consts.svh"
module alarm_event_block #(
	parameter int N_SETS = 8,
	parameter int N_REC = 12,
	parameter int MS_CYCLES = `MS_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic meas_valid,
	input wire dir_alarm_pkg::meas_s meas,
	input wire logic blocking,
	output logic start,
	output logic alarm,
	output dir_alarm_pkg::event_s alarm_event
);
	import dir_alarm_pkg::*;

	localparam int HOLD = `HOLD_PERIODS;
	localparam int LAG = `LAG_PERIODS;
	localparam int DW = $clog2(MS_CYCLES + 1);

	// refuse sizes that the selector, the record index or the divider cannot serve
	if (N_SETS != 8 || N_REC < 1 || N_REC > 16 || MS_CYCLES < 1) begin : g_bad_params
		$error("alarm_event_block: unsupported parameters");
	end

	// ************************************************
	// parameter sets and control registers
	// ************************************************
	logic [15:0] thr_q [N_SETS];
	logic [2:0] mode_q [N_SETS];
	logic [10:0] size_q [N_SETS];
	logic [12:0] centre_q [N_SETS];
	logic [2:0] act_q;
	logic [2:0] edit_q;
	logic [3:0] rec_idx_q;
	logic [15:0] count_q;
	logic [31:0] rdata_q;

	// write decode
	wire wr_ctrl = wr && addr == `OFS_CTRL;
	wire wr_edit = wr && addr == `OFS_EDIT;
	wire wr_thr = wr && addr == `OFS_THR;
	wire wr_mode = wr && addr == `OFS_MODE;
	wire wr_size = wr && addr == `OFS_SIZE;
	wire wr_centre = wr && addr == `OFS_CENTRE;
	wire wr_ridx = wr && addr == `OFS_REC_IDX;
	wire clr_req = wr_ctrl && wdata[`CTRL_CLR_BIT];
	// out-of-range settings are clamped to the legal span
	wire [15:0] thr_w = wdata[15:0] < `THR_MIN ? `THR_MIN :
		(wdata[15:0] > `THR_MAX ? `THR_MAX : wdata[15:0]);
	wire [10:0] size_w = wdata[10:0] < `SIZE_MIN ? `SIZE_MIN :
		(wdata[10:0] > `SIZE_MAX ? `SIZE_MAX : wdata[10:0]);
	wire signed [12:0] cw = wdata[12:0];
	wire [12:0] centre_w = cw > $signed(`ANG_HALF) ? 13'(`ANG_HALF) :
		(cw < -$signed(`ANG_HALF) ? 13'(-`ANG_HALF) : wdata[12:0]);

	// set storage, edited through one window while the active set runs
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int s = 0; s < N_SETS; s++) begin
				thr_q[s] <= `THR_RESET; // [R8]
				mode_q[s] <= 3'h0; // [R9]
				size_q[s] <= `SIZE_RESET; // [R10]
				centre_q[s] <= `CENTRE_RESET; // [R11]
			end
		end else begin
			if (wr_thr)
				thr_q[edit_q] <= thr_w; // [R1] [R8]
			if (wr_mode)
				mode_q[edit_q] <= {wdata[4], wdata[1:0] == 2'h3 ? 2'h0 : wdata[1:0]};
			if (wr_size)
				size_q[edit_q] <= size_w; // [R10]
			if (wr_centre)
				centre_q[edit_q] <= centre_w; // [R11]
		end
	end

	// selector, edit pointer, record index
	always_ff @(posedge clk) begin
		if (reset) begin
			act_q <= 3'h0;
			edit_q <= 3'h0;
			rec_idx_q <= 4'h0;
		end else begin
			if (wr_ctrl)
				act_q <= wdata[2:0]; // [R1]
			if (wr_edit)
				edit_q <= wdata[2:0];
			if (wr_ridx)
				rec_idx_q <= wdata[3:0];
		end
	end

	// active set fields
	wire [15:0] thr = thr_q[act_q];
	wire [1:0] dir = mode_q[act_q][1:0];
	wire p2p_mode = mode_q[act_q][2];
	wire [10:0] size = size_q[act_q];
	wire signed [12:0] centre = centre_q[act_q];

	// ************************************************
	// magnitude comparison per phase
	// ************************************************
	logic [2:0] pick_q;
	logic [2:0] pick_d;
	logic [15:0] mag [3];
	wire [22:0] thr_full = 23'(thr) * 23'(`FULL_PCT);
	wire [22:0] thr_rel = 23'(thr) * 23'(`RESET_PCT);

	for (genvar p = 0; p < 3; p++) begin : g_phase
		assign mag[p] = p2p_mode ? meas.p2p[p] : meas.rms[p]; // [R4]
		wire [22:0] m100 = 23'(mag[p]) * 23'(`FULL_PCT);
		// over threshold picks up, stays until below 97 %
		assign pick_d[p] = pick_q[p] ? m100 >= thr_rel : m100 > thr_full; // [R6] [R7]
	end

	// largest phase of this period
	wire [15:0] mag_ab = mag[0] > mag[1] ? mag[0] : mag[1];
	wire [15:0] mag_max = mag_ab > mag[2] ? mag_ab : mag[2];

	// ************************************************
	// reference angle and angle memory
	// ************************************************
	logic signed [12:0] hist_q [LAG];
	logic signed [12:0] mem_q;
	logic [7:0] hold_q;
	logic low_q;

	// every voltage channel under 1 V means collapse
	wire [3:0] vlow;
	for (genvar v = 0; v < 4; v++) begin : g_volt
		assign vlow[v] = meas.volt[v] < `LOW_VOLT;
	end
	wire volt_low = &vlow;
	// live reference: impedance, positive sequence, or healthy line voltage
	wire signed [12:0] live_ref = meas.short_circ ? meas.imp_ang : // [R15]
		(meas.u1_ok ? meas.u1_ang : meas.ll_ang); // [R13] [R14]
	wire signed [12:0] cur_ang = meas.u1_ok ? meas.i1_ang : meas.flt_ang; // [R14]
	wire expired = hold_q >= 8'(HOLD);
	wire signed [12:0] ref_ang = !volt_low ? live_ref :
		(expired ? 13'h0000 : (low_q ? mem_q : hist_q[LAG - 1])); // [R16] [R18]

	// history line, one entry per period without collapse, oldest at the tail
	always_ff @(posedge clk) begin
		if (meas_valid && !volt_low) begin
			hist_q[0] <= live_ref; // [R17]
			for (int k = 1; k < LAG; k++)
				hist_q[k] <= hist_q[k - 1];
		end
	end

	// hold timer counts periods spent in collapse
	always_ff @(posedge clk) begin
		if (reset) begin
			low_q <= 1'b0;
			hold_q <= 8'h00;
			mem_q <= 13'h0000;
		end else if (meas_valid) begin
			low_q <= volt_low;
			if (volt_low && !low_q)
				mem_q <= hist_q[LAG - 1]; // [R17]
			if (!volt_low)
				hold_q <= 8'h00;
			else if (!expired)
				hold_q <= hold_q + 8'h01; // [R16]
		end
	end

	// ************************************************
	// direction check
	// ************************************************
	function automatic logic signed [12:0] wrap_ang(input logic signed [14:0] a);
		logic signed [14:0] t;
		t = a;
		for (int i = 0; i < 2; i++) begin
			if (t > $signed(`ANG_HALF))
				t = t - $signed(`ANG_FULL);
			else if (t < -$signed(`ANG_HALF))
				t = t + $signed(`ANG_FULL);
		end
		return t[12:0];
	endfunction

	logic ang_q;
	wire signed [14:0] rev_ofs = dir == 2'(DIR_REV) ? $signed(`ANG_HALF) : 15'sh0000;
	wire signed [12:0] diff = wrap_ang(15'(cur_ang) - 15'(ref_ang) - 15'(centre) + rev_ofs);
	wire [12:0] diff_abs = diff < 0 ? 13'(-diff) : 13'(diff);
	wire [12:0] lim = 13'(size) + (ang_q ? 13'(`ANG_HYST) : 13'h0000); // [R19]
	wire ang_d = dir == 2'(DIR_NONDIR) || diff_abs <= lim; // [R9] [R12]
	wire start_d = |pick_d && ang_d && !blocking; // [R20]
	wire alarm_d = start_d; // [R22]

	logic start_q;
	logic alarm_q;
	logic signed [12:0] diff_q;
	// period results held until the next measurement, angle kept for the records
	always_ff @(posedge clk) begin
		if (reset) begin
			pick_q <= 3'h0;
			ang_q <= 1'b0;
			diff_q <= 13'h0000;
			start_q <= 1'b0;
			alarm_q <= 1'b0;
		end else if (meas_valid) begin
			pick_q <= pick_d;
			ang_q <= ang_d;
			diff_q <= diff; // [R21]
			start_q <= start_d; // [R20]
			alarm_q <= alarm_d; // [R12] [R22]
		end
	end

	// ************************************************
	// millisecond time base and events
	// ************************************************
	logic [DW-1:0] div_q;
	logic [31:0] ms_q;
	wire ms_tick = div_q == DW'(MS_CYCLES - 1);
	always_ff @(posedge clk) begin
		if (reset) begin
			div_q <= '0;
			ms_q <= 32'h0000_0000;
		end else begin
			div_q <= ms_tick ? '0 : div_q + DW'(1);
			if (ms_tick)
				ms_q <= ms_q + 32'h0000_0001; // [R2]
		end
	end

	logic alarm_prev_q;
	event_s ev_q;
	wire change = alarm_q != alarm_prev_q;
	wire on_ev = change && alarm_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			alarm_prev_q <= 1'b0;
			ev_q <= '0;
		end else begin
			alarm_prev_q <= alarm_q;
			ev_q <= '{valid: change, on: alarm_q, stamp: ms_q}; // [R2]
		end
	end

	// counter: an ON event in the clearing cycle is kept
	always_ff @(posedge clk) begin
		if (reset)
			count_q <= 16'h0000;
		else if (on_ev)
			count_q <= clr_req ? 16'h0001 : count_q + 16'h0001; // [R3]
		else if (clr_req)
			count_q <= 16'h0000; // [R3]
	end

	// ************************************************
	// operation records, ring of the latest entries
	// ************************************************
	logic [31:0] rec_stamp_q [N_REC];
	logic [31:0] rec_info_q [N_REC];
	logic [31:0] rec_max_q [N_REC];
	logic [3:0] wp_q;
	logic [15:0] ep_max_q;
	logic [2:0] ep_ph_q;
	wire [15:0] ep_max_d = mag_max > ep_max_q ? mag_max : ep_max_q;

	// episode peak and faulted phases, captured while picked up
	always_ff @(posedge clk) begin
		if (reset) begin
			ep_max_q <= 16'h0000;
			ep_ph_q <= 3'h0;
		end else if (meas_valid) begin
			ep_max_q <= |pick_d ? ep_max_d : 16'h0000;
			ep_ph_q <= |pick_d ? (ep_ph_q | pick_d) : 3'h0;
		end
	end

	// one record per alarm change
	always_ff @(posedge clk) begin
		if (reset) begin
			wp_q <= 4'h0;
		end else if (change) begin
			rec_stamp_q[wp_q] <= ms_q; // [R21]
			rec_info_q[wp_q] <= {7'h00, act_q, ep_ph_q | pick_q, 4'(dir), 1'b0,
				alarm_q, diff_q}; // [R21]
			rec_max_q[wp_q] <= {thr, ep_max_q};
			wp_q <= wp_q == 4'(N_REC - 1) ? 4'h0 : wp_q + 4'h1;
		end
	end

	// ************************************************
	// read path, data one cycle after the strobe
	// ************************************************
	wire [3:0] ri = rec_idx_q < 4'(N_REC) ? rec_idx_q : 4'h0;
	wire [31:0] status = {21'h000000, wp_q, 1'b0, ang_q, pick_q, start_q, alarm_q};
	wire [31:0] rmux =
		addr == `OFS_CTRL ? {29'h0, act_q} :
		addr == `OFS_STATUS ? status :
		addr == `OFS_COUNT ? {16'h0000, count_q} :
		addr == `OFS_EDIT ? {29'h0, edit_q} :
		addr == `OFS_THR ? {16'h0000, thr_q[edit_q]} :
		addr == `OFS_MODE ? {27'h0, mode_q[edit_q][2], 2'h0, mode_q[edit_q][1:0]} :
		addr == `OFS_SIZE ? {21'h0, size_q[edit_q]} :
		addr == `OFS_CENTRE ? {{19{centre_q[edit_q][12]}}, centre_q[edit_q]} :
		addr == `OFS_REC_IDX ? {28'h0, rec_idx_q} :
		addr == `OFS_REC_STAMP ? rec_stamp_q[ri] :
		addr == `OFS_REC_INFO ? rec_info_q[ri] :
		addr == `OFS_REC_MAX ? rec_max_q[ri] : 32'h0000_0000;
	always_ff @(posedge clk) begin
		if (reset)
			rdata_q <= 32'h0000_0000;
		else
			rdata_q <= rd ? rmux : 32'h0000_0000;
	end

	assign rdata = rdata_q;
	assign start = start_q;
	assign alarm = alarm_q;
	assign alarm_event = ev_q;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_rise;
		!alarm_q ##1 alarm_q;
	endsequence
	sequence s_on_event;
		ev_q.valid && ev_q.on && ev_q.stamp == $past(ms_q);
	endsequence
	property p_on_event;
		s_rise |=> s_on_event;
	endproperty
	a_event_on_stamp: assert property (p_on_event) // [R2]
		else $error("no stamped ON event after alarm rise");
	a_event_off: assert property ($fell(alarm_q) |=> ev_q.valid && !ev_q.on) // [R2]
		else $error("no OFF event after alarm fall");
	a_count_clear: assert property (clr_req && !on_ev |=> count_q == 16'h0000) // [R3]
		else $error("counter not cleared");
	a_count_step: assert property (on_ev && !clr_req |=> count_q == $past(count_q) + 16'h0001) // [R3]
		else $error("counter missed an ON event");
	a_start_blocked: assert property (meas_valid && blocking |=> !start_q [*2]) // [R20]
		else $error("start raised while blocked");
	a_alarm_needs_angle: assert property (meas_valid && !ang_d |=> !alarm_q) // [R12]
		else $error("alarm without angle condition");
	a_nondir_angle: assert property (meas_valid && dir == 2'(DIR_NONDIR) |=> ang_q) // [R9]
		else $error("angle check in non-directional mode");
	a_pickup_hyst: assert property (meas_valid && pick_q[0] &&
		23'(mag[0]) * 23'(`FULL_PCT) >= thr_rel |=> pick_q[0]) // [R7]
		else $error("phase released above 97 percent");
	a_pickup_over: assert property (meas_valid && 23'(mag[1]) * 23'(`FULL_PCT) > thr_full
		|=> pick_q[1]) // [R6]
		else $error("phase over threshold not picked up");
	a_hold_zero: assert property (volt_low && expired |-> ref_ang == 13'h0000) // [R18]
		else $error("reference not forced to zero after hold");
endmodule
`default_nettype wire

// [dir_alarm_consts.svh]
// constants for the directional overcurrent alarm: offsets, fields, resets, timing
// assumes byte addresses on a 32-bit register port, angles in 0.1 degree units
`ifndef DIR_ALARM_CONSTS_SVH
`define DIR_ALARM_CONSTS_SVH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_COUNT 8'h08
`define OFS_EDIT 8'h0C
`define OFS_THR 8'h10
`define OFS_MODE 8'h14
`define OFS_SIZE 8'h18
`define OFS_CENTRE 8'h1C
`define OFS_REC_IDX 8'h20
`define OFS_REC_STAMP 8'h24
`define OFS_REC_INFO 8'h28
`define OFS_REC_MAX 8'h2C
// field positions
`define CTRL_CLR_BIT 8
// reset values and limits of a parameter set (0.01 x In, 0.1 degree)
`define THR_RESET 16'h0078
`define THR_MIN 16'h000A
`define THR_MAX 16'h0FA0
`define SIZE_RESET 11'h370
`define SIZE_MIN 11'h00A
`define SIZE_MAX 11'h6A4
`define CENTRE_RESET 13'h0000
// hysteresis, angle and voltage figures
`define RESET_PCT 7'h61
`define FULL_PCT 7'h64
`define ANG_HYST 11'h014
`define ANG_HALF 15'h0708
`define ANG_FULL 15'h0E10
`define LOW_VOLT 16'h0064
// timing: times in their own unit, counts derived
`define CLK_NS 4
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_NS)
`define PERIOD_MS 5
`define HOLD_MS 500
`define LAG_MS 100
`define HOLD_PERIODS (`HOLD_MS / `PERIOD_MS)
`define LAG_PERIODS (`LAG_MS / `PERIOD_MS)
`endif

// [dir_alarm_pkg.sv]
// types shared by the directional overcurrent alarm and its surroundings
// assumes magnitudes in 0.01 units and signed angles in 0.1 degree units
package dir_alarm_pkg;
	typedef enum logic [1:0] {DIR_FWD, DIR_REV, DIR_NONDIR} dir_e;
	typedef logic signed [12:0] angle_t;
	// one measurement period from the measurement subsystem
	typedef struct packed {
		logic [2:0][15:0] rms;
		logic [2:0][15:0] p2p;
		logic [3:0][15:0] volt;
		logic u1_ok;
		logic short_circ;
		angle_t u1_ang;
		angle_t i1_ang;
		angle_t ll_ang;
		angle_t flt_ang;
		angle_t imp_ang;
	} meas_s;
	// alarm change event toward the shared event buffer
	typedef struct packed {
		logic valid;
		logic on;
		logic [31:0] stamp;
	} event_s;
endpackage

// [meas_source.sv]
// measurement subsystem model: hands one frame per measurement period to the alarm block
// assumes the bench requests each period with go; lag delays the answer by that many cycles
`timescale 1ns/1ns
`default_nettype none
module meas_source (
	input wire logic clk,
	input wire logic reset,
	input wire logic go,
	input wire logic [3:0] lag,
	input wire dir_alarm_pkg::meas_s frame,
	output logic meas_valid,
	output dir_alarm_pkg::meas_s meas
);
	import dir_alarm_pkg::*;
	// ****************
	// period launcher
	// ****************
	logic busy_q;
	logic [3:0] wait_q;
	// one frame of three currents and four voltages per request, inverse pattern otherwise
	always_ff @(posedge clk) begin
		meas_valid <= 1'b0;
		meas <= meas_s'(~frame);
		if (reset) begin
			busy_q <= 1'b0;
			wait_q <= 4'h0;
		end else if (go) begin
			busy_q <= 1'b1;
			wait_q <= lag;
		end else if (busy_q && wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
		end else if (busy_q) begin
			busy_q <= 1'b0;
			meas_valid <= 1'b1;
			meas <= frame;
		end
	end
endmodule
`default_nettype wire

// [testbench.sv]
// testbench for the directional overcurrent alarm: register calls and measurement periods
// assumes the design files and meas_source.sv are compiled before it
`timescale 1ns/1ns
`default_nettype none
`include "dir_alarm_consts.svh"
module testbench;
	import dir_alarm_pkg::*;
	// ****************
	// signals and instances
	// ****************
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic go = 1'b0;
	logic blocking = 1'b0;
	logic prev = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] lag = 4'h0;
	logic [31:0] rdata;
	logic meas_valid;
	logic alarm;
	logic start;
	meas_s fr;
	meas_s meas;
	event_s alarm_event;
	int n_fail = 0;
	int n_compared = 0;
	// clock of 4 ns
	always #2 clk = ~clk;
	alarm_event_block #(.MS_CYCLES(10)) dut (.clk(clk), .reset(reset), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .meas_valid(meas_valid), .meas(meas),
		.blocking(blocking), .start(start), .alarm(alarm), .alarm_event(alarm_event));
	meas_source src (.clk(clk), .reset(reset), .go(go), .lag(lag), .frame(fr),
		.meas_valid(meas_valid), .meas(meas));
	// ****************
	// tasks
	// ****************
	// report and end the run
	task automatic conclude(input logic timed_out);
		if (timed_out) n_fail++;
		$display("Comparisons %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// compare one value
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one write cycle
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// one read cycle, data looked at in the following cycle
	task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk($sformatf("register %h", a), exp, rdata);
	endtask
	// one measurement period, then alarm, start and the event that follows
	task automatic step(input logic exp);
		int i;
		i = 0;
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		while (meas_valid !== 1'b1 && i < 40) begin
			@(posedge clk);
			i++;
		end
		if (i == 40) conclude(1'b1);
		@(negedge clk);
		chk("alarm", {31'h0, exp}, {31'h0, alarm});
		chk("start", {31'h0, exp}, {31'h0, start});
		@(negedge clk);
		chk("event valid", {31'h0, exp != prev}, {31'h0, alarm_event.valid});
		if (exp != prev) chk("event on", {31'h0, exp}, {31'h0, alarm_event.on});
		prev = exp;
	endtask
	// ****************
	// tests
	// ****************
	initial begin
		fr = '0;
		fr.volt = {4{16'h03E8}};
		fr.u1_ok = 1'b1;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		// reset values, unmapped place and clamping
		rreg(`OFS_THR, {16'h0, `THR_RESET});
		rreg(`OFS_SIZE, {21'h0, `SIZE_RESET});
		rreg(`OFS_CENTRE, 32'h0);
		rreg(`OFS_MODE, 32'h0);
		wreg(`OFS_MODE, 32'h3);
		rreg(`OFS_MODE, 32'h0);
		wreg(`OFS_CENTRE, 32'h1000);
		rreg(`OFS_CENTRE, 32'hFFFFF8F8);
		wreg(`OFS_CENTRE, 32'h0);
		wreg(8'h30, 32'hFFFF);
		rreg(8'h30, 32'h0);
		wreg(`OFS_THR, 32'h5);
		rreg(`OFS_THR, {16'h0, `THR_MIN});
		wreg(`OFS_THR, {16'h0, `THR_RESET});
		$display("test registers done");
		// each phase alone, threshold edge
		step(1'b0);
		for (int p = 0; p < 3; p++) begin
			fr.rms[p] = 16'h0078;
			step(1'b0);
			fr.rms[p] = 16'h0079;
			step(1'b1);
			fr.rms[p] = 16'h0000;
			step(1'b0);
		end
		// release below 97 percent only
		fr.rms[0] = 16'h0079;
		step(1'b1);
		fr.rms[0] = 16'h0075;
		step(1'b1);
		fr.rms[0] = 16'h0074;
		step(1'b0);
		$display("test pick-up done");
		// sector edge and angle hysteresis
		fr.rms[0] = 16'h00C8;
		fr.i1_ang = 13'h0385;
		step(1'b0);
		fr.i1_ang = 13'h0371;
		step(1'b0);
		fr.i1_ang = 13'h0370;
		step(1'b1);
		fr.i1_ang = 13'h0384;
		step(1'b1);
		fr.i1_ang = 13'h0385;
		step(1'b0);
		// direction codes
		wreg(`OFS_MODE, 32'h1);
		fr.i1_ang = 13'h0000;
		step(1'b0);
		fr.i1_ang = 13'h18F8;
		step(1'b1);
		wreg(`OFS_MODE, 32'h0);
		step(1'b0);
		wreg(`OFS_MODE, 32'h2);
		step(1'b1);
		wreg(`OFS_MODE, 32'h0);
		fr.i1_ang = 13'h0000;
		step(1'b1);
		wreg(`OFS_CENTRE, 32'h3E8);
		step(1'b0);
		fr.i1_ang = 13'h03E8;
		step(1'b1);
		wreg(`OFS_CENTRE, 32'h0);
		$display("test direction done");
		// reference sources
		fr.u1_ang = 13'h03E8;
		fr.i1_ang = 13'h03E8;
		step(1'b1);
		fr.short_circ = 1'b1;
		step(1'b0);
		fr.imp_ang = 13'h03E8;
		step(1'b1);
		fr.short_circ = 1'b0;
		fr.u1_ok = 1'b0;
		fr.flt_ang = 13'h03E8;
		step(1'b0);
		fr.ll_ang = 13'h03E8;
		step(1'b1);
		fr.u1_ok = 1'b1;
		fr.u1_ang = 13'h0000;
		fr.i1_ang = 13'h0000;
		step(1'b1);
		// blocking gates start
		@(posedge clk);
		blocking <= 1'b1;
		step(1'b0);
		@(posedge clk);
		blocking <= 1'b0;
		step(1'b1);
		$display("test references done");
		// angle memory through a voltage collapse, slow answers
		lag = 4'h3;
		fr.u1_ang = 13'h04B0;
		fr.i1_ang = 13'h04B0;
		repeat (22) step(1'b1);
		fr.volt = '0;
		fr.u1_ang = 13'h0000;
		repeat (100) step(1'b1);
		step(1'b0);
		fr.volt = {4{16'h03E8}};
		fr.i1_ang = 13'h0000;
		lag = 4'h0;
		step(1'b1);
		$display("test memory done");
		// parameter sets switched while running
		wreg(`OFS_EDIT, 32'h3);
		wreg(`OFS_THR, 32'h01F4);
		wreg(`OFS_CTRL, 32'h3);
		step(1'b0);
		rreg(`OFS_THR, 32'h01F4);
		wreg(`OFS_CTRL, 32'h0);
		step(1'b1);
		wreg(`OFS_EDIT, 32'h0);
		rreg(`OFS_THR, {16'h0, `THR_RESET});
		// peak-to-peak magnitudes
		fr.rms[0] = 16'h0000;
		step(1'b0);
		wreg(`OFS_MODE, 32'h10);
		fr.p2p[0] = 16'h00C8;
		step(1'b1);
		wreg(`OFS_MODE, 32'h0);
		step(1'b0);
		// counter clear and count
		rreg(`OFS_COUNT, 32'hE);
		wreg(`OFS_CTRL, 32'h100);
		rreg(`OFS_COUNT, 32'h0);
		rreg(`OFS_CTRL, 32'h0);
		fr.rms[0] = 16'h00C8;
		step(1'b1);
		rreg(`OFS_COUNT, 32'h1);
		rreg(`OFS_STATUS, 32'h2A7);
		wreg(`OFS_REC_IDX, 32'h4);
		rreg(`OFS_REC_INFO, 32'h0008_2000);
		rreg(`OFS_REC_MAX, 32'h0078_00C8);
		$display("test sets and counter done");
		conclude(1'b0);
	end
endmodule
`default_nettype wire
